// ==== verilog/csc_cfg.svh ====
/*
 file: offsets, field positions, reset values and codes for the status and core control words.
 assumes: included by the package and the design module by bare name.
*/
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
`define CSC_ADDR_W 4
`define CSC_OFS_STATUS 4'h0
`define CSC_OFS_CORE 4'h1
`define CSC_OFS_EXT 4'h2
// status word bits
`define SW_OA 15
`define SW_OB 14
`define SW_SA 13
`define SW_SB 12
`define SW_OAB 11
`define SW_SAB 10
`define SW_DA 9
`define SW_DC 8
`define SW_IPL_HI 7
`define SW_IPL_LO 5
`define SW_RA 4
`define SW_N 3
`define SW_OV 2
`define SW_Z 1
`define SW_C 0
// core control bits
`define CC_VAR 15
`define CC_US_HI 13
`define CC_US_LO 12
`define CC_EDT 11
`define CC_DL_HI 10
`define CC_DL_LO 8
`define CC_ACCUM_A_CLIP_ENABLE 7
`define CC_ACCUM_B_CLIP_ENABLE 6
`define CC_MEM_WRITE_CLIP_ENABLE 5
`define CC_CLIP_WIDTH_MODE 4
`define CC_PRIORITY_LEVEL_MSB 3
`define CC_SFA 2
`define CC_RND 1
`define CC_IF 0
`define CC_RESET 16'h0020
`define CC_WR_MASK 16'hB0F3
`define IPL_ALL_ONES 3'h7
`define US_SIGNED 2'h0
`define US_UNSIGNED 2'h1
`define US_MIXED 2'h2
`define SW_ZERO 16'h0000
`define NIB_CARRY_BIT 4
`define BYTE_CARRY_BIT 8
`define BYTE_SIGN 7
`define WORD_SIGN 15
`endif

// ==== verilog/csc_pkg.sv ====
/*
 file: types for the status and core control bank.
 assumes: the cfg header defines the numbers.
*/
`include "csc_cfg.svh"
package csc_pkg;
   typedef logic [15:0] csc_word_t;
   typedef logic [1:0] csc_sign_t;
   typedef struct packed {
      logic [15:0] rdata;
      logic [15:0] status;
      logic [15:0] core;
      logic early_exit;
   } csc_state_s;
endpackage : csc_pkg

// ==== verilog/csc_regs.sv ====
/*
 file: status word and core control word with the flag update logic.
 assumes: a simple strobe register port, one clock, synchronous active high reset;
 the datapath delivers flag events and loop state as synchronous inputs.
*/
// Functional notes
// - accumulator overflow flags follow overflow state
// - clip flags are sticky until software clears
// - any-overflow is OR of overflow flags
// - any-clip is OR of sticky clip flags
// - clip flags written directly or via any-clip
// - loop active bits are read-only loop state
// - half carry from nibble or byte carry
// - priority level joins msb above low field
// - low priority field locked while nesting disabled
// - negative flag follows result sign
// - overflow flag on signed overflow
// - zero flag cleared by nonzero, set by zero result
// - carry flag from msb carry out
// - variable exception latency select bit
// - multiply sign mode field select
// - early exit write one pulses, reads zero
// - nesting depth field shows active loop count
// - saturation enables, write clip resets set
// - clip width mode selects super saturation
// - stack frame bit widens W14/W15 range
// - rounding mode bit selects biased rounding
// - integer or fractional multiply mode bit
// - carry bits act as inverted borrows on subtraction
`include "csc_cfg.svh"
module csc_regs (
   input wire logic mclk_in, // core clock
   input wire logic rst_in, // sync reset, high
   input wire logic clk_en_in, // freezes state when low
   input wire logic [`CSC_ADDR_W-1:0] addr_in, // register index
   input wire csc_pkg::csc_word_t wdata_in, // write data
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   output csc_pkg::csc_word_t rdata_out, // read data, cycle after strobe
   input wire logic acc_a_ovf_in, // accumulator a overflowed
   input wire logic acc_b_ovf_in, // accumulator b overflowed
   input wire logic acc_a_sat_in, // accumulator a saturated
   input wire logic acc_b_sat_in, // accumulator b saturated
   input wire logic do_active_in, // do loop running
   input wire logic rep_active_in, // repeat loop running
   input wire logic [2:0] do_depth_in, // active do loop count
   input wire logic stack_frame_in, // stack frame active
   input wire logic alu_valid_in, // alu result strobe
   input wire logic alu_byte_in, // byte sized op
   input wire logic alu_sub_in, // subtraction
   input wire logic [16:0] alu_a_in, // operand a (bit16 unused zero)
   input wire logic [16:0] alu_b_in, // operand b
   input wire logic alu_upd_z_in, // op affects zero flag
   input wire logic nesting_disable_in, // lock priority field
   output logic [3:0] cpu_priority_level_out, // full priority level
   output logic user_irq_disable_out, // user interrupts blocked
   output logic flexible_exc_latency_out, // variable exception latency
   output csc_pkg::csc_sign_t multiply_sign_mode_out, // multiply signedness
   output logic early_loop_exit_out, // one cycle exit pulse
   output logic accum_a_clip_enable_out, // sat enable a
   output logic accum_b_clip_enable_out, // sat enable b
   output logic mem_write_clip_enable_out, // sat on data writes
   output logic clip_width_mode_out, // 9.31 when high
   output logic stack_frame_active_out, // full range W14/W15
   output logic rounding_mode_out, // biased when high
   output logic integer_fraction_mode_out // integer when high
);
   import csc_pkg::*;

   csc_state_s state_reg;
   csc_state_s state_next;

   // add or subtract at word width, borrow reported as carry out inverted
   function automatic logic [16:0] alu_sum(input logic [16:0] a, input logic [16:0] b,
                                           input logic sub);
      alu_sum = sub ? (a + {1'b0, ~b[15:0]} + 17'h00001) : (a + b);
   endfunction : alu_sum

   logic [16:0] sum;
   logic [4:0] nib_sum;
   logic [8:0] byte_sum;
   logic msb_carry;
   logic half_carry;
   logic res_neg;
   logic res_ovf;
   logic res_zero;
   logic sgn_a;
   logic sgn_b;
   logic sgn_r;
   logic sw_wr;
   logic cc_wr;

   // flag computation from the alu operands
   always_comb begin
      sum = alu_sum(alu_a_in, alu_b_in, alu_sub_in);
      nib_sum = {1'b0, alu_a_in[3:0]} + (alu_sub_in ? {1'b0, ~alu_b_in[3:0]} + 5'h01
                                                    : {1'b0, alu_b_in[3:0]});
      byte_sum = {1'b0, alu_a_in[7:0]} + (alu_sub_in ? {1'b0, ~alu_b_in[7:0]} + 9'h001
                                                     : {1'b0, alu_b_in[7:0]});
      // carry out means no borrow on subtraction
      half_carry = alu_byte_in ? nib_sum[`NIB_CARRY_BIT] : byte_sum[`BYTE_CARRY_BIT];
      msb_carry = alu_byte_in ? byte_sum[`BYTE_CARRY_BIT] : sum[16];
      sgn_a = alu_byte_in ? alu_a_in[`BYTE_SIGN] : alu_a_in[`WORD_SIGN];
      sgn_b = alu_byte_in ? alu_b_in[`BYTE_SIGN] : alu_b_in[`WORD_SIGN];
      sgn_r = alu_byte_in ? byte_sum[`BYTE_SIGN] : sum[`WORD_SIGN];
      res_neg = sgn_r;
      // sign changed against operands of matching effective sign
      res_ovf = ((sgn_a == (sgn_b ^ alu_sub_in)) && (sgn_r != sgn_a));
      res_zero = alu_byte_in ? (byte_sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);
   end

   // next state: writes first, hardware events override so no event is lost
   always_comb begin
      state_next = state_reg;
      sw_wr = wr_in && (addr_in == `CSC_OFS_STATUS);
      cc_wr = wr_in && (addr_in == `CSC_OFS_CORE);
      state_next.early_exit = 1'b0;
      if (sw_wr) begin
         state_next.status[`SW_OA] = wdata_in[`SW_OA];
         state_next.status[`SW_OB] = wdata_in[`SW_OB];
         state_next.status[`SW_SA] = wdata_in[`SW_SA];
         state_next.status[`SW_SB] = wdata_in[`SW_SB];
         if (!wdata_in[`SW_SAB]) begin
            // clearing the combined bit clears both sticky flags
            state_next.status[`SW_SA] = 1'b0;
            state_next.status[`SW_SB] = 1'b0;
         end
         state_next.status[`SW_DC] = wdata_in[`SW_DC];
         if (!nesting_disable_in) begin
            state_next.status[`SW_IPL_HI:`SW_IPL_LO] = wdata_in[`SW_IPL_HI:`SW_IPL_LO];
         end
         state_next.status[`SW_N:`SW_C] = wdata_in[`SW_N:`SW_C];
      end
      if (cc_wr) begin
         state_next.core = (state_reg.core & ~`CC_WR_MASK) | (wdata_in & `CC_WR_MASK);
         // priority msb is clear-only from software
         state_next.core[`CC_PRIORITY_LEVEL_MSB] = state_reg.core[`CC_PRIORITY_LEVEL_MSB] & wdata_in[`CC_PRIORITY_LEVEL_MSB];
         state_next.early_exit = wdata_in[`CC_EDT];
      end
      // overflow mirrors current accumulator state
      state_next.status[`SW_OA] = acc_a_ovf_in;
      state_next.status[`SW_OB] = acc_b_ovf_in;
      // sticky: set wins over a same-cycle clear
      if (acc_a_sat_in) state_next.status[`SW_SA] = 1'b1;
      if (acc_b_sat_in) state_next.status[`SW_SB] = 1'b1;
      state_next.status[`SW_OAB] = state_next.status[`SW_OA] | state_next.status[`SW_OB];
      state_next.status[`SW_SAB] = state_next.status[`SW_SA] | state_next.status[`SW_SB];
      state_next.status[`SW_DA] = do_active_in;
      state_next.status[`SW_RA] = rep_active_in;
      if (alu_valid_in) begin
         state_next.status[`SW_DC] = half_carry;
         state_next.status[`SW_N] = res_neg;
         state_next.status[`SW_OV] = res_ovf;
         state_next.status[`SW_C] = msb_carry;
         if (alu_upd_z_in && !res_zero) begin
            state_next.status[`SW_Z] = 1'b0;
         end else if (alu_upd_z_in) begin
            state_next.status[`SW_Z] = 1'b1;
         end
      end
      state_next.core[`CC_EDT] = 1'b0;
      state_next.core[`CC_DL_HI:`CC_DL_LO] = do_depth_in;
      state_next.core[`CC_SFA] = stack_frame_in;
      state_next.core[14] = 1'b0;
      // read data valid only in the cycle after the strobe
      state_next.rdata = `SW_ZERO;
      if (rd_in) begin
         unique case (addr_in)
            `CSC_OFS_STATUS: state_next.rdata = state_reg.status;
            `CSC_OFS_CORE: state_next.rdata = state_reg.core;
            default: state_next.rdata = `SW_ZERO;
         endcase
      end
   end

   // single register stage; clock enable freezes everything
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_reg.rdata <= `SW_ZERO;
         state_reg.status <= `SW_ZERO;
         state_reg.core <= `CC_RESET;
         state_reg.early_exit <= 1'b0;
      end else if (clk_en_in) begin
         state_reg <= state_next;
      end
   end

   logic [3:0] prio_reg;
   logic udis_reg;
   // derived outputs registered from the next state so every output is a flop (in step with the state)
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         prio_reg <= 4'h0;
         udis_reg <= 1'b0;
      end else if (clk_en_in) begin
         prio_reg <= {state_next.core[`CC_PRIORITY_LEVEL_MSB], state_next.status[`SW_IPL_HI:`SW_IPL_LO]};
         udis_reg <= state_next.core[`CC_PRIORITY_LEVEL_MSB] ||
                     (state_next.status[`SW_IPL_HI:`SW_IPL_LO] == `IPL_ALL_ONES);
      end
   end

   assign rdata_out = state_reg.rdata;
   assign cpu_priority_level_out = prio_reg;
   assign user_irq_disable_out = udis_reg;
   assign flexible_exc_latency_out = state_reg.core[`CC_VAR];
   assign multiply_sign_mode_out = state_reg.core[`CC_US_HI:`CC_US_LO];
   assign early_loop_exit_out = state_reg.early_exit;
   assign accum_a_clip_enable_out = state_reg.core[`CC_ACCUM_A_CLIP_ENABLE];
   assign accum_b_clip_enable_out = state_reg.core[`CC_ACCUM_B_CLIP_ENABLE];
   assign mem_write_clip_enable_out = state_reg.core[`CC_MEM_WRITE_CLIP_ENABLE];
   assign clip_width_mode_out = state_reg.core[`CC_CLIP_WIDTH_MODE];
   assign stack_frame_active_out = state_reg.core[`CC_SFA];
   assign rounding_mode_out = state_reg.core[`CC_RND];
   assign integer_fraction_mode_out = state_reg.core[`CC_IF];

   // checks
   a_sticky_clip: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && acc_a_sat_in |=> state_reg.status[`SW_SA]) else $error("clip a lost");
   a_any_ovf: assert property (@(posedge mclk_in) disable iff (rst_in)
      state_reg.status[`SW_OAB] == (state_reg.status[`SW_OA] | state_reg.status[`SW_OB]))
      else $error("oab mismatch");
   a_any_clip: assert property (@(posedge mclk_in) disable iff (rst_in)
      state_reg.status[`SW_SAB] == (state_reg.status[`SW_SA] | state_reg.status[`SW_SB]))
      else $error("sab mismatch");
   a_ipl_lock: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && nesting_disable_in && !$past(rst_in) |=>
      $stable(state_reg.status[`SW_IPL_HI:`SW_IPL_LO])) else $error("ipl written");
   a_edt_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
      early_loop_exit_out && clk_en_in && !(cc_wr && wdata_in[`CC_EDT]) |=>
      !early_loop_exit_out) else $error("edt long");
   a_edt_reads: assert property (@(posedge mclk_in) disable iff (rst_in)
      !state_reg.core[`CC_EDT]) else $error("edt reads one");
   a_zero_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && alu_valid_in && alu_upd_z_in && !res_zero |=> !state_reg.status[`SW_Z])
      else $error("z not cleared");
   a_udis_prio: assert property (@(posedge mclk_in) disable iff (rst_in)
      user_irq_disable_out == (cpu_priority_level_out[3] ||
      cpu_priority_level_out[2:0] == `IPL_ALL_ONES)) else $error("udis wrong");
   a_ovf_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in ##1 1'b1 |-> state_reg.status[`SW_OA] == $past(acc_a_ovf_in))
      else $error("oa wrong");

   // loop state bits are plain mirrors of the sequencer, one cycle late
   a_do_mirror: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in |=> state_reg.status[`SW_DA] == $past(do_active_in))
      else $error("do active wrong");

   a_rep_mirror: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in |=> state_reg.status[`SW_RA] == $past(rep_active_in))
      else $error("repeat active wrong");

   // software can never leave a stale depth behind: hardware owns the field
   a_depth_mirror: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in |=> state_reg.core[`CC_DL_HI:`CC_DL_LO] == $past(do_depth_in))
      else $error("depth wrong");

   a_frame_mirror: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in |=> state_reg.core[`CC_SFA] == $past(stack_frame_in))
      else $error("frame bit wrong");

   // two word addends with both top bits set must carry out of the msb
   a_carry_set: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && alu_valid_in && !alu_sub_in && !alu_byte_in &&
      alu_a_in[`WORD_SIGN] && alu_b_in[`WORD_SIGN] |=> state_reg.status[`SW_C])
      else $error("carry missed");

   // low nibble 0xF plus one always carries into the upper nibble
   a_half_carry: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && alu_valid_in && !alu_sub_in && alu_byte_in &&
      alu_a_in[3:0] == 4'hF && alu_b_in[3:0] == 4'h1 |=> state_reg.status[`SW_DC])
      else $error("half carry missed");

   // negative flag tracks the sign of the word result
   a_neg_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && alu_valid_in && !alu_byte_in |=>
      state_reg.status[`SW_N] == $past(sum[`WORD_SIGN]))
      else $error("negative wrong");

   // two positive word addends giving a negative sum is a signed overflow
   a_ovf_add: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && alu_valid_in && !alu_sub_in && !alu_byte_in &&
      !alu_a_in[`WORD_SIGN] && !alu_b_in[`WORD_SIGN] && sum[`WORD_SIGN] |=>
      state_reg.status[`SW_OV]) else $error("overflow missed");

   a_zero_set: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && alu_valid_in && alu_upd_z_in && res_zero |=> state_reg.status[`SW_Z])
      else $error("z not set");

   // clearing the combined bit drops both sticky flags unless a new event lands
   a_clip_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && sw_wr && !wdata_in[`SW_SAB] && !acc_a_sat_in && !acc_b_sat_in |=>
      !state_reg.status[`SW_SA] && !state_reg.status[`SW_SB])
      else $error("clip not cleared");

   // nothing inside this bank may raise the priority msb
   a_msb_clear_only: assert property (@(posedge mclk_in) disable iff (rst_in)
      !state_reg.core[`CC_PRIORITY_LEVEL_MSB] |=> !state_reg.core[`CC_PRIORITY_LEVEL_MSB])
      else $error("priority msb set");

   // reset must leave data write saturation enabled and all else clear
   a_core_reset: assert property (@(posedge mclk_in)
      rst_in |=> state_reg.core == `CC_RESET) else $error("core reset wrong");

   // holes in the map read back as zero
   a_unmapped_rd: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && rd_in && addr_in != `CSC_OFS_STATUS && addr_in != `CSC_OFS_CORE |=>
      rdata_out == `SW_ZERO) else $error("unmapped read nonzero");

   c_alu_zero: cover property (@(posedge mclk_in) alu_valid_in && res_zero);
   c_ipl_lock: cover property (@(posedge mclk_in) nesting_disable_in && sw_wr);
   c_sat_set: cover property (@(posedge mclk_in) acc_a_sat_in ##1 state_reg.status[`SW_SA]);
   c_udis: cover property (@(posedge mclk_in) user_irq_disable_out);
endmodule : csc_regs

// ==== test/cpu_status_core_control_tb.sv ====
/*
 file: self-checking bench for the status and core control register bank.
 assumes: csc_pkg and csc_cfg.svh compiled first; reads answer one cycle after the strobe.
*/
`include "csc_cfg.svh"
module cpu_status_core_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import csc_pkg::*;
   logic mclk_in = 0, rst_in = 1, clk_en_in = 1, wr_in = 0, rd_in = 0;
   logic [3:0] addr_in = 0;
   csc_word_t wdata_in = 0, rdata_out;
   logic a_ovf = 0, b_ovf = 0, a_sat = 0, b_sat = 0, do_act = 0, rep_act = 0, stack_frame_active = 0;
   logic [2:0] depth = 0;
   logic alu_v = 0, alu_byte = 0, alu_sub = 0, nest_dis = 0, rd_d = 0;
   logic [16:0] alu_a = 0, alu_b = 0;
   logic [3:0] lvl;
   logic irq_dis, var_lat, early_loop_exit, cla, clb, cmw, cwm, sfa_o, rnd, ifm;
   csc_sign_t us;
   csc_word_t exp_q[$];
   int n_errors = 0, n_tests = 0;
   csc_regs dut (.mclk_in(mclk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .acc_a_ovf_in(a_ovf), .acc_b_ovf_in(b_ovf), .acc_a_sat_in(a_sat), .acc_b_sat_in(b_sat),
      .do_active_in(do_act), .rep_active_in(rep_act), .do_depth_in(depth),
      .stack_frame_in(stack_frame_active), .alu_valid_in(alu_v), .alu_byte_in(alu_byte),
      .alu_sub_in(alu_sub), .alu_a_in(alu_a), .alu_b_in(alu_b), .alu_upd_z_in(1'b1),
      .nesting_disable_in(nest_dis), .cpu_priority_level_out(lvl),
      .user_irq_disable_out(irq_dis), .flexible_exc_latency_out(var_lat),
      .multiply_sign_mode_out(us), .early_loop_exit_out(early_loop_exit), .accum_a_clip_enable_out(cla),
      .accum_b_clip_enable_out(clb), .mem_write_clip_enable_out(cmw),
      .clip_width_mode_out(cwm), .stack_frame_active_out(sfa_o), .rounding_mode_out(rnd),
      .integer_fraction_mode_out(ifm));
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // the read answer stands one cycle only, so look at it in exactly that cycle
   always @(posedge mclk_in) begin
      if (rd_d) begin
         if (exp_q.size() == 0) chk("unexpected read", 16'h0000, 16'hFFFF);
         else chk("rdata", exp_q.pop_front(), rdata_out);
      end
      rd_d = rd_in & clk_en_in;
   end
   task automatic wr(input logic [3:0] a, input csc_word_t d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, input csc_word_t e);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk_in);
      rd_in <= 1'b0;
   endtask : rd
   task automatic test_done;
      if (exp_q.size() != 0) n_errors++;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // expected alu flags; subtraction adds the inverse plus one, so carry means no borrow
   function automatic csc_word_t alu_exp(input logic [15:0] a, input logic [15:0] b,
                                         input logic by, input logic sb);
      logic [15:0] bb;
      logic [16:0] s;
      logic [8:0] lo;
      logic [4:0] nb;
      csc_word_t f;
      bb = sb ? ~b : b;
      s = a + bb + sb;
      lo = a[7:0] + bb[7:0] + sb;
      nb = a[3:0] + bb[3:0] + sb;
      f = 16'h0000;
      if (by) f[8] = nb[4];
      else f[8] = lo[8];
      f[0] = by ? lo[8] : s[16];
      f[3] = by ? lo[7] : s[15];
      f[2] = by ? (a[7] == bb[7]) && (lo[7] != a[7]) : (a[15] == bb[15]) && (s[15] != a[15]);
      f[1] = by ? (lo[7:0] == 8'h00) : (s[15:0] == 16'h0000);
      return f;
   endfunction : alu_exp
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_errors++;
      test_done();
   end
   initial begin : main
      csc_word_t w;
      logic [15:0] a, b;
      void'($urandom(32'h07763066));
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      rd(0, 16'h0000);
      rd(1, `CC_RESET);
      rd(2, 16'h0000);
      chk("write clip enable", 16'h0001, {15'h0, cmw});
      $display("test reset done");
      // every sign mode code, random other fields, random loop depth and frame state
      for (int i = 0; i < 4; i++) begin
         w = $urandom();
         w[13:12] = i;
         depth <= $urandom();
         stack_frame_active <= $urandom();
         wr(1, w);
         chk("core outputs", {w[15], w[13:12], w[7:4], stack_frame_active, w[1:0]},
             {var_lat, us, cla, clb, cmw, cwm, sfa_o, rnd, ifm});
         rd(1, (w & `CC_WR_MASK) | {5'h0, depth, 5'h0, stack_frame_active, 2'h0});
      end
      wr(1, 16'h0800);
      chk("exit pulse", 16'h0001, {15'h0, early_loop_exit});
      @(posedge mclk_in);
      #1 chk("exit pulse end", 16'h0000, {15'h0, early_loop_exit});
      clk_en_in <= 1'b0;
      wr(1, 16'h00F3);
      clk_en_in <= 1'b1;
      rd(1, {5'h0, depth, 5'h0, stack_frame_active, 2'h0});
      $display("test core done");
      @(posedge mclk_in);
      a_ovf <= 1'b1;
      b_sat <= 1'b1;
      do_act <= 1'b1;
      rep_act <= 1'b1;
      @(posedge mclk_in);
      b_sat <= 1'b0;
      @(posedge mclk_in);
      rd(0, 16'h9E10);
      a_ovf <= 1'b0;
      do_act <= 1'b0;
      rep_act <= 1'b0;
      b_ovf <= 1'b1;
      a_sat <= 1'b1;
      @(posedge mclk_in);
      a_sat <= 1'b0;
      b_ovf <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rd(0, 16'h3400);
      wr(0, 16'h3000);
      rd(0, 16'h0000);
      $display("test accumulator flags done");
      wr(0, 16'h00E0);
      chk("priority", 16'h0007, {12'h0, lvl});
      chk("irq blocked", 16'h0001, {15'h0, irq_dis});
      nest_dis <= 1'b1;
      wr(0, 16'h0020);
      rd(0, 16'h00E0);
      nest_dis <= 1'b0;
      wr(0, 16'h0040);
      chk("priority low", 16'h0002, {7'h0, irq_dis, 4'h0, lvl});
      $display("test priority done");
      wr(0, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         a = $urandom();
         b = (i < 2) ? (i == 0 ? a : -a) : $urandom();
         @(posedge mclk_in);
         alu_a <= {1'b0, a};
         alu_b <= {1'b0, b};
         alu_byte <= i[0] ^ i[2];
         alu_sub <= (i == 0) | i[1];
         alu_v <= 1'b1;
         @(posedge mclk_in);
         alu_v <= 1'b0;
         rd(0, alu_exp(a, b, i[0] ^ i[2], (i == 0) | i[1]));
      end
      repeat (3) @(posedge mclk_in);
      $display("test alu flags done");
      test_done();
   end
endmodule : cpu_status_core_control_tb
